// ===== logic/dmi_defines.vh
/*
  Constants for the data-move and indirect-access executor: widths,
  instruction encodings, field positions and reset values.
  Assumes it is included by bare name from the design file.
*/
`ifndef DMI_DEFINES_VH
`define DMI_DEFINES_VH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define DMI_INSTR_W 14
`define DMI_ACC_W 8
`define DMI_PTR_W 16
`define DMI_BANK_W 5
`define DMI_PCH_W 7
`define DMI_MEM_AW 8
`define DMI_MEM_DEPTH 256

// ---------------------------------------------------------------
// Instruction encodings as mask and match pairs
// ---------------------------------------------------------------
`define DMI_IND_MASK 14'h3FF0
`define DMI_IND_MATCH 14'h0010
`define DMI_REL_MASK 14'h3F00
`define DMI_REL_MATCH 14'h3F00
`define DMI_BANK_MASK 14'h3FE0
`define DMI_BANK_MATCH 14'h0020
`define DMI_PCH_MASK 14'h3F80
`define DMI_PCH_MATCH 14'h3180
`define DMI_LIT_MASK 14'h3F00
`define DMI_LIT_MATCH 14'h3000
`define DMI_STORE_MASK 14'h3F80
`define DMI_STORE_MATCH 14'h0080

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DMI_IND_DIR_BIT 3
`define DMI_IND_SEL_BIT 2
`define DMI_REL_DIR_BIT 7
`define DMI_REL_SEL_BIT 6
`define DMI_REL_OFS_MSB 5

// ---------------------------------------------------------------
// Pointer update modes and window addresses
// ---------------------------------------------------------------
`define DMI_MODE_PREINC 2'h0
`define DMI_MODE_PREDEC 2'h1
`define DMI_MODE_POSTINC 2'h2
`define DMI_MODE_POSTDEC 2'h3
`define DMI_WIN0_ADDR 7'h00
`define DMI_WIN1_ADDR 7'h01

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define DMI_ACC_RST 8'h00
`define DMI_PTR_RST 16'h0000
`define DMI_BANK_RST 5'h00
`define DMI_PCH_RST 7'h00

`endif

// ===== logic/dmi_core.v
/*
  Single-cycle executor for the data-move group of an 8-bit core:
  indirect read and write through two 16-bit pointers, literal loads
  of bank select, program-counter high latch and accumulator, and the
  accumulator store to a file register. It holds its own data memory.
  Assumes one instruction word is offered per clock with instrValid,
  synchronous to clock, and that other instructions are decoded
  elsewhere.
*/
//
// Behaviour
// (RQ1) Indirect read loads byte at pointer address into acc, sets zero.
// (RQ2) Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// (RQ3) Pre modes access pointer plus or minus one.
// (RQ4) Pointer ends at plus or minus one; offset form leaves it.
// (RQ5) Offset form accesses pointer plus signed offset -32..31.
// (RQ6) Window registers have no storage; they reach the pointed byte.
// (RQ7) Pointers are 16 bits and wrap at both ends.
// (RQ8) Bank load writes its literal into bank select, no flags.
// (RQ9) Latch load writes 7-bit literal into pc high latch, no flags.
// (RQ10) Literal load puts 8-bit literal into acc in one cycle.
// (RQ11) Acc store writes acc to 7-bit file address in one cycle.
// (RQ12) Pointer updates never change any status flag.
// (RQ13) Indirect moves finish in one cycle with pointer write-back.
`include "dmi_defines.vh"

module dmi_core
(
  input wire clock,
  input wire rst,
  input wire instrValid,
  input wire [`DMI_INSTR_W-1:0] instrWord,
  input wire ptrLoadEn,
  input wire ptrLoadSel,
  input wire [`DMI_PTR_W-1:0] ptrLoadValue,
  input wire [`DMI_MEM_AW-1:0] dbgAddr,
  output wire [`DMI_ACC_W-1:0] accOut,
  output wire zeroFlag,
  output wire [`DMI_BANK_W-1:0] bankSelOut,
  output wire [`DMI_PCH_W-1:0] pcHighOut,
  output wire [`DMI_PTR_W-1:0] ptr0Out,
  output wire [`DMI_PTR_W-1:0] ptr1Out,
  output wire doneOut,
  output wire unknownOut,
  output wire [`DMI_ACC_W-1:0] dbgData
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [`DMI_ACC_W-1:0] acc_reg;
  reg [`DMI_ACC_W-1:0] acc_next;
  reg zero_reg;
  reg zero_next;
  reg [`DMI_BANK_W-1:0] bank_reg;
  reg [`DMI_BANK_W-1:0] bank_next;
  reg [`DMI_PCH_W-1:0] pch_reg;
  reg [`DMI_PCH_W-1:0] pch_next;
  reg [`DMI_PTR_W-1:0] ptr0_reg;
  reg [`DMI_PTR_W-1:0] ptr0_next;
  reg [`DMI_PTR_W-1:0] ptr1_reg;
  reg [`DMI_PTR_W-1:0] ptr1_next;
  reg done_reg;
  reg unknown_reg;
  reg [`DMI_ACC_W-1:0] dbg_reg;
  reg [`DMI_ACC_W-1:0] dataMem [0:`DMI_MEM_DEPTH-1];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  reg isIndirect;
  reg isRelative;
  reg isBank;
  reg isPcHigh;
  reg isLiteral;
  reg isStore;
  reg isWindow;
  reg writeDir;
  reg selPtr;
  reg [1:0] updMode;
  reg [`DMI_PTR_W-1:0] curPtr;
  reg [`DMI_PTR_W-1:0] incPtr;
  reg [`DMI_PTR_W-1:0] decPtr;
  reg [`DMI_PTR_W-1:0] updPtr;
  reg [`DMI_PTR_W-1:0] relOfs;
  reg [`DMI_PTR_W-1:0] effAddr;
  reg [11:0] directAddr;
  reg [`DMI_MEM_AW-1:0] memAddr;
  reg memWrite;
  reg [`DMI_ACC_W-1:0] readData;

  always @*
  begin
    isIndirect = instrValid &&
      ((instrWord & `DMI_IND_MASK) == `DMI_IND_MATCH);
    isRelative = instrValid &&
      ((instrWord & `DMI_REL_MASK) == `DMI_REL_MATCH);
    isBank = instrValid &&
      ((instrWord & `DMI_BANK_MASK) == `DMI_BANK_MATCH);
    isPcHigh = instrValid &&
      ((instrWord & `DMI_PCH_MASK) == `DMI_PCH_MATCH);
    isLiteral = instrValid &&
      ((instrWord & `DMI_LIT_MASK) == `DMI_LIT_MATCH);
    isStore = instrValid &&
      ((instrWord & `DMI_STORE_MASK) == `DMI_STORE_MATCH);
    // A store naming a window register is redirected through a pointer.
    isWindow = isStore &&
      ((instrWord[6:0] == `DMI_WIN0_ADDR) ||
       (instrWord[6:0] == `DMI_WIN1_ADDR)); // RQ6
    updMode = instrWord[1:0]; // RQ2
    writeDir = 1'h0;
    selPtr = 1'h0;
    if (isIndirect)
    begin
      writeDir = instrWord[`DMI_IND_DIR_BIT];
      selPtr = instrWord[`DMI_IND_SEL_BIT]; // RQ1
    end
    else if (isRelative)
    begin
      writeDir = instrWord[`DMI_REL_DIR_BIT];
      selPtr = instrWord[`DMI_REL_SEL_BIT];
    end
    else if (isWindow)
    begin
      selPtr = instrWord[0];
    end
  end

  // ---------------------------------------------------------------
  // Address
  // ---------------------------------------------------------------
  always @*
  begin
    curPtr = selPtr ? ptr1_reg : ptr0_reg;
    // Sixteen-bit arithmetic wraps at both ends of the range.
    incPtr = curPtr + 16'h0001; // RQ7
    decPtr = curPtr - 16'h0001; // RQ7
    case (updMode)
      `DMI_MODE_PREINC: updPtr = incPtr;
      `DMI_MODE_PREDEC: updPtr = decPtr;
      `DMI_MODE_POSTINC: updPtr = incPtr;
      `DMI_MODE_POSTDEC: updPtr = decPtr;
      default: updPtr = curPtr;
    endcase
    // The six-bit offset is sign-extended so it can reach back 32 bytes.
    relOfs = {{10{instrWord[`DMI_REL_OFS_MSB]}}, instrWord[5:0]};
    if (isRelative)
    begin
      effAddr = curPtr + relOfs; // RQ5
    end
    else if (isIndirect &&
      ((updMode == `DMI_MODE_PREINC) || (updMode == `DMI_MODE_PREDEC)))
    begin
      effAddr = updPtr; // RQ3
    end
    else
    begin
      effAddr = curPtr;
    end
    // Only the lowest bank bit reaches the 256-byte memory. The upper
    // bank bits are kept for software but select nothing here, so banks
    // alias onto the two halves of the memory.
    directAddr = {bank_reg, instrWord[6:0]};
    if (isStore && !isWindow)
    begin
      memAddr = directAddr[`DMI_MEM_AW-1:0]; // RQ11
    end
    else
    begin
      memAddr = effAddr[`DMI_MEM_AW-1:0]; // RQ6
    end
    memWrite = ((isIndirect || isRelative) && writeDir) || isStore;
    // The memory is read without a clock so that a read completes in the
    // same cycle as the pointer update that goes with it.
    readData = dataMem[memAddr];
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always @*
  begin
    acc_next = acc_reg;
    zero_next = zero_reg;
    bank_next = bank_reg;
    pch_next = pch_reg;
    ptr0_next = ptr0_reg;
    ptr1_next = ptr1_reg;
    // The preload is applied first so that an instruction's own write-back
    // to the same pointer overrides it.
    if (ptrLoadEn)
    begin
      if (ptrLoadSel)
      begin
        ptr1_next = ptrLoadValue;
      end
      else
      begin
        ptr0_next = ptrLoadValue;
      end
    end
    if (isIndirect)
    begin
      // Write-back lands in the same cycle as the transfer; flags stay.
      if (selPtr)
      begin
        ptr1_next = updPtr; // RQ4
      end
      else
      begin
        ptr0_next = updPtr; // RQ4
      end
    end
    // The pointer is left alone for the offset form; a read of either form loads acc and sets the zero flag.
    if ((isIndirect || isRelative) && !writeDir)
    begin
      acc_next = readData; // RQ1
      zero_next = (readData == 8'h00); // RQ1
    end
    if (isBank)
    begin
      bank_next = instrWord[4:0]; // RQ8
    end
    if (isPcHigh)
    begin
      pch_next = instrWord[6:0]; // RQ9
    end
    if (isLiteral)
    begin
      acc_next = instrWord[7:0]; // RQ10
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      acc_reg <= `DMI_ACC_RST;
      zero_reg <= 1'h0;
      bank_reg <= `DMI_BANK_RST;
      pch_reg <= `DMI_PCH_RST;
      ptr0_reg <= `DMI_PTR_RST;
      ptr1_reg <= `DMI_PTR_RST;
      done_reg <= 1'h0;
      unknown_reg <= 1'h0;
    end
    else
    begin
      acc_reg <= acc_next;
      zero_reg <= zero_next; // RQ12
      bank_reg <= bank_next;
      pch_reg <= pch_next;
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next; // RQ13
      // The done and unknown pulses last one cycle and never overlap.
      done_reg <= isIndirect || isRelative || isBank || isPcHigh ||
        isLiteral || isStore;
      unknown_reg <= instrValid && !(isIndirect || isRelative ||
        isBank || isPcHigh || isLiteral || isStore);
    end
  end

  // ---------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------
  // The memory has no reset. Writes are held off while reset is high so
  // that a word presented during reset cannot land.
  always @(posedge clock)
  begin
    if (memWrite && !rst)
    begin
      dataMem[memAddr] <= acc_reg; // RQ11
    end
  end

  // The debug read is registered, so it shows the byte as it stood before
  // any write at the same edge.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dbg_reg <= 8'h00;
    end
    else
    begin
      dbg_reg <= dataMem[dbgAddr];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign accOut = acc_reg;
  assign zeroFlag = zero_reg;
  assign bankSelOut = bank_reg;
  assign pcHighOut = pch_reg;
  assign ptr0Out = ptr0_reg;
  assign ptr1Out = ptr1_reg;
  assign doneOut = done_reg;
  assign unknownOut = unknown_reg;
  assign dbgData = dbg_reg;

endmodule

// ===== sim/dmi_core_props.sv
/*
  Concurrent checks on the ports of dmi_core, bound to every instance.
  Assumes inputs change only away from the rising clock edge.
*/
`include "dmi_defines.vh"
module dmi_core_props
(
  input wire clock,
  input wire rst,
  input wire instrValid,
  input wire [`DMI_INSTR_W-1:0] instrWord,
  input wire ptrLoadEn,
  input wire [`DMI_ACC_W-1:0] accOut,
  input wire zeroFlag,
  input wire [`DMI_BANK_W-1:0] bankSelOut,
  input wire [`DMI_PCH_W-1:0] pcHighOut,
  input wire [`DMI_PTR_W-1:0] ptr0Out,
  input wire [`DMI_PTR_W-1:0] ptr1Out,
  input wire doneOut,
  input wire unknownOut
);
  timeunit 1ns;
  timeprecision 1ps;
  wire isInd = (instrWord & `DMI_IND_MASK) == `DMI_IND_MATCH;
  wire isRel = (instrWord & `DMI_REL_MASK) == `DMI_REL_MATCH;
  wire isBank = (instrWord & `DMI_BANK_MASK) == `DMI_BANK_MATCH;
  wire isPch = (instrWord & `DMI_PCH_MASK) == `DMI_PCH_MATCH;
  wire isLit = (instrWord & `DMI_LIT_MASK) == `DMI_LIT_MATCH;
  wire isSto = (instrWord & `DMI_STORE_MASK) == `DMI_STORE_MATCH;
  wire isRd = (isInd && !instrWord[3]) || (isRel && !instrWord[7]);
  wire isHit = isInd || isRel || isBank || isPch || isLit || isSto;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_lit;
    instrValid && isLit |=> accOut == $past(instrWord[7:0]);
  endproperty
  a_lit: assert property (p_lit) else $error("literal load wrong");
  property p_bank;
    instrValid && isBank |=> bankSelOut == $past(instrWord[4:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank load wrong");
  property p_pch;
    instrValid && isPch |=> pcHighOut == $past(instrWord[6:0]);
  endproperty
  a_pch: assert property (p_pch) else $error("latch load wrong");
  property p_inc0;
    instrValid && isInd && !instrWord[2] && !instrWord[0]
      |=> ptr0Out == $past(ptr0Out) + 16'h0001;
  endproperty
  a_inc0: assert property (p_inc0) else $error("pointer inc wrong");
  property p_dec1;
    instrValid && isInd && instrWord[2] && instrWord[0]
      |=> ptr1Out == $past(ptr1Out) - 16'h0001;
  endproperty
  a_dec1: assert property (p_dec1) else $error("pointer dec wrong");
  property p_rel;
    instrValid && isRel && !ptrLoadEn |=> $stable(ptr0Out) && $stable(ptr1Out);
  endproperty
  a_rel: assert property (p_rel) else $error("offset moved pointer");
  property p_zero;
    !(instrValid && isRd) |=> $stable(zeroFlag);
  endproperty
  a_zero: assert property (p_zero) else $error("flag changed");
  property p_rdz;
    instrValid && isRd |=> zeroFlag == (accOut == 8'h00);
  endproperty
  a_rdz: assert property (p_rdz) else $error("zero flag wrong");
  property p_done;
    instrValid && isHit |=> doneOut && !unknownOut;
  endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_unk;
    !(instrValid && isHit) |=> !doneOut && unknownOut == $past(instrValid);
  endproperty
  a_unk: assert property (p_unk) else $error("unknown pulse wrong");
endmodule

bind dmi_core dmi_core_props u_props (.clock(clock), .rst(rst),
  .instrValid(instrValid), .instrWord(instrWord), .ptrLoadEn(ptrLoadEn),
  .accOut(accOut), .zeroFlag(zeroFlag), .bankSelOut(bankSelOut),
  .pcHighOut(pcHighOut), .ptr0Out(ptr0Out), .ptr1Out(ptr1Out),
  .doneOut(doneOut), .unknownOut(unknownOut));

// ===== sim/tb_top.sv
/*
  Self-checking bench for dmi_core with a reference model in tasks.
  Assumes the design header is on the include path.
*/
`include "dmi_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst = 1, instrValid = 0, ptrLoadEn = 0, ptrLoadSel = 0;
  logic [13:0] instrWord = '0, r;
  logic [15:0] ptrLoadValue = '0;
  logic [7:0] dbgAddr = '0, accOut, dbgData, mAcc = '0;
  logic zeroFlag, doneOut, unknownOut, mZero = 0, mDone, mUnk;
  logic [4:0] bankSelOut, mBank = '0;
  logic [6:0] pcHighOut, mPch = '0;
  logic [15:0] ptr0Out, ptr1Out, mPtr [0:1] = '{16'h0000, 16'h0000};
  logic [7:0] mMem [0:255];
  logic [13:0] mk [0:5] = '{`DMI_IND_MASK, `DMI_REL_MASK, `DMI_BANK_MASK,
    `DMI_PCH_MASK, `DMI_LIT_MASK, `DMI_STORE_MASK};
  logic [13:0] mt [0:5] = '{`DMI_IND_MATCH, `DMI_REL_MATCH, `DMI_BANK_MATCH,
    `DMI_PCH_MATCH, `DMI_LIT_MATCH, `DMI_STORE_MATCH};
  integer seed = 42, errTotal = 0, testsRun = 0, i, j;
  always #12.5 clock = ~clock;
  dmi_core DUT (.clock(clock), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .ptrLoadEn(ptrLoadEn), .ptrLoadSel(ptrLoadSel),
    .ptrLoadValue(ptrLoadValue), .dbgAddr(dbgAddr), .accOut(accOut),
    .zeroFlag(zeroFlag), .bankSelOut(bankSelOut), .pcHighOut(pcHighOut),
    .ptr0Out(ptr0Out), .ptr1Out(ptr1Out), .doneOut(doneOut),
    .unknownOut(unknownOut), .dbgData(dbgData));
  task automatic chk(input logic [15:0] got, exp, input string what);
    testsRun++;
    if (got !== exp)
    begin
      errTotal++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // One clock of stimulus, mirrored in the model, then checked.
  // ----------------------------------------------------------------
  task automatic step(input logic [13:0] w, input logic v, le, ls,
    input logic [15:0] lv);
    logic [15:0] ea, np;
    logic n, d, hit, wb;
    logic [7:0] dv;
    {instrValid, instrWord, ptrLoadEn, ptrLoadSel} = {v, w, le, ls};
    ptrLoadValue = lv;
    dbgAddr = 8'($random(seed));
    dv = mMem[dbgAddr];
    {n, d, hit, wb, np, ea} = '0;
    if (v && (w & `DMI_IND_MASK) == `DMI_IND_MATCH)
    begin
      {d, n, wb, hit} = {w[3:2], 2'h3};
      np = w[0] ? mPtr[n] - 16'h0001 : mPtr[n] + 16'h0001;
      ea = w[1] ? mPtr[n] : np;
    end
    if (v && (w & `DMI_REL_MASK) == `DMI_REL_MATCH)
    begin
      {d, n, hit} = {w[7:6], 1'h1};
      ea = mPtr[n] + {{10{w[5]}}, w[5:0]};
    end
    if (hit && d)
      mMem[ea[7:0]] = mAcc;
    else if (hit)
      {mAcc, mZero} = {mMem[ea[7:0]], mMem[ea[7:0]] == 8'h00};
    if (v && (w & `DMI_BANK_MASK) == `DMI_BANK_MATCH)
      {hit, mBank} = {1'h1, w[4:0]};
    if (v && (w & `DMI_PCH_MASK) == `DMI_PCH_MATCH)
      {hit, mPch} = {1'h1, w[6:0]};
    if (v && (w & `DMI_LIT_MASK) == `DMI_LIT_MATCH)
      {hit, mAcc} = {1'h1, w[7:0]};
    if (v && (w & `DMI_STORE_MASK) == `DMI_STORE_MATCH)
    begin
      hit = 1'h1;
      ea = w[6:1] == 6'h00 ? mPtr[w[0]] : {mBank[0], w[6:0]};
      mMem[ea[7:0]] = mAcc;
    end
    if (le && !(wb && n == ls))
      mPtr[ls] = lv;
    if (wb)
      mPtr[n] = np;
    {mDone, mUnk} = {hit, v && !hit};
    @(posedge clock);
    #2;
    chk(accOut, mAcc, "acc");
    chk(zeroFlag, mZero, "zero");
    chk(bankSelOut, mBank, "bank");
    chk(pcHighOut, mPch, "latch");
    chk(ptr0Out, mPtr[0], "ptr0");
    chk(ptr1Out, mPtr[1], "ptr1");
    chk({doneOut, unknownOut}, {mDone, mUnk}, "pulse");
    chk(dbgData, dv, "debug");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200us;
    errTotal++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge clock);
    #2;
    rst = 0;
    step(14'h0000, 0, 1, 0, 16'h0000);
    for (i = 0; i < 256; i++)
    begin
      step({6'h30, i[2:0] ? 8'($random(seed)) : 8'h00}, 1, 0, 0, '0);
      step(14'h001A, 1, 0, 0, '0);
    end
    step(14'h0000, 0, 1, 0, 16'hFFFF);
    step(14'h0010, 1, 1, 1, 16'h0000);
    step(14'h0017, 1, 0, 0, '0);
    for (i = 0; i < 16; i++)
      step(14'h0010 | i[13:0], 1, 0, 0, '0);
    step(14'h3F20, 1, 0, 0, '0);
    step(14'h3FDF, 1, 0, 0, '0);
    step(14'h0080, 1, 0, 0, '0);
    step(14'h0081, 1, 0, 0, '0);
    step(14'h002F, 1, 0, 0, '0);
    step(14'h31FF, 1, 0, 0, '0);
    step(14'h3000, 1, 0, 0, '0);
    for (i = 0; i < 3000; i++)
    begin
      j = {$random(seed)} % 7;
      r = 14'($random(seed));
      if (j < 6)
        r = (r & ~mk[j]) | mt[j];
      step(r, i[0] | i[1], (i % 5) == 0, i[2], 16'($random(seed)));
    end
    report_and_stop;
  end
endmodule
